// *** hw/csw_flag_encoder.sv ***
// encodes condition levels into the 32-bit information flag word
// assumes conditions are synchronous levels ordered as the package codes
`timescale 1ns/10ps
`default_nettype none
module csw_flag_encoder
(
   input wire logic [csw_pkg::CSW_NUM_COND-1:0] cond, // condition levels
   output logic [31:0] flags // or of active codes
);
   import csw_pkg::*;
   localparam logic [31:0] CODES [CSW_NUM_COND] = '{
      CSW_INF_USER_IO, CSW_INF_TEMP, CSW_INF_TCP_SPEED,
      CSW_INF_JNT_SPEED, CSW_INF_START_ERR, CSW_INF_HOME_ERR,
      CSW_INF_TCP_POS, CSW_INF_TCP_NEG,
      CSW_INF_JNT_POS, CSW_INF_JNT_NEG,
      CSW_INF_INHIBIT, CSW_INF_SINGULAR, CSW_INF_POSTURE,
      CSW_INF_DRV_CONN, CSW_INF_DRV_DET,
      CSW_INF_RESTRICT, CSW_INF_IO_TEST, CSW_INF_REBOOT
   };
   // or together every active code; unused bits stay zero
   always_comb
   begin
      flags = CSW_ZERO;
      for (int i = 0; i < CSW_NUM_COND; i++)
      begin
         if (cond[i])
         begin
            flags = flags | CODES[i];
         end
      end
   end
endmodule
`default_nettype wire

// *** hw/csw_pkg.sv ***
// package for the controller status words register bank
// assumes an axi4-lite host with 32-bit data and byte addressing
package csw_pkg;
   // register byte offsets
   localparam logic [11:0] CSW_ADDR_INFO = 12'h0000; // information flags
   localparam logic [11:0] CSW_ADDR_DIO = 12'h01a8; // direct i/o, index 0x6a
   localparam logic [11:0] CSW_ADDR_IIN = 12'h0004; // internal input status
   localparam logic [11:0] CSW_ADDR_IRQ_STAT = 12'h0008; // sticky events
   localparam logic [11:0] CSW_ADDR_IRQ_MASK = 12'h000c; // event mask
   localparam logic [7:0] CSW_DIO_INDEX = 8'h6a; // printed direct i/o index
   // information flag codes
   localparam logic [31:0] CSW_INF_USER_IO = 32'h0000_0001;
   localparam logic [31:0] CSW_INF_TEMP = 32'h0000_0004;
   localparam logic [31:0] CSW_INF_TCP_SPEED = 32'h0000_0080;
   localparam logic [31:0] CSW_INF_JNT_SPEED = 32'h0000_0100;
   localparam logic [31:0] CSW_INF_START_ERR = 32'h0000_0200;
   localparam logic [31:0] CSW_INF_HOME_ERR = 32'h0000_0400;
   localparam logic [31:0] CSW_INF_TCP_POS = 32'h0001_0000;
   localparam logic [31:0] CSW_INF_TCP_NEG = 32'h0002_0000;
   localparam logic [31:0] CSW_INF_JNT_POS = 32'h0004_0000;
   localparam logic [31:0] CSW_INF_JNT_NEG = 32'h0008_0000;
   localparam logic [31:0] CSW_INF_INHIBIT = 32'h0010_0000;
   localparam logic [31:0] CSW_INF_SINGULAR = 32'h0020_0000;
   localparam logic [31:0] CSW_INF_POSTURE = 32'h0040_0000;
   localparam logic [31:0] CSW_INF_DRV_CONN = 32'h0400_0000;
   localparam logic [31:0] CSW_INF_DRV_DET = 32'h0800_0000;
   localparam logic [31:0] CSW_INF_RESTRICT = 32'h1000_0000;
   localparam logic [31:0] CSW_INF_IO_TEST = 32'h2000_0000;
   localparam logic [31:0] CSW_INF_REBOOT = 32'h8000_0000;
   localparam int CSW_NUM_COND = 18; // number of information conditions
   // direct i/o layout
   localparam int CSW_DIO_IN_LSB = 0;
   localparam int CSW_DIO_OUT_LSB = 16;
   // internal input layout
   localparam int CSW_IIN_PANEL = 30;
   localparam int CSW_IIN_DRV_CLR = 29;
   localparam int CSW_IIN_CNT_CLR = 28;
   localparam int CSW_IIN_GEN_CLR = 27;
   localparam int CSW_IIN_OVT_CLR = 25;
   // axi responses
   localparam logic [1:0] CSW_RESP_OKAY = 2'b00;
   localparam logic [1:0] CSW_RESP_SLVERR = 2'b10;
   localparam logic [31:0] CSW_ZERO = 32'h0000_0000;
endpackage

// *** hw/csw_status_regs.sv ***
// read-only controller status words behind an axi4-lite slave
// assumes all inputs synchronous to core_clk, one reset
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module csw_status_regs
(
   input wire logic core_clk, // 20 mhz clock
   input wire logic rst, // async reset, active high
   input wire logic [csw_pkg::CSW_NUM_COND-1:0] info_cond, // condition levels
   input wire logic [7:0] phys_input, // phys_input_0..7
   input wire logic [7:0] phys_output, // phys_output_0..7
   input wire logic panel_interface_bit, // panel interface state
   input wire logic drive_info_clear_req, // drive info clear request
   input wire logic counter_info_clear_req, // counter info clear request
   input wire logic general_info_clear_req, // general info clear request
   input wire logic drive_overtravel_clear_req, // overtravel clear request
   input wire logic [11:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // write byte strobes
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [11:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read valid
   input wire logic s_axi_rready, // read ready
   output logic irq // level interrupt
);
   import csw_pkg::*;

   // whole state of the block
   typedef struct packed {
      logic aw_got; // write address held
      logic w_got; // write data held
      logic [11:0] awaddr; // held write address
      logic [31:0] wdata; // held write data
      logic [3:0] wstrb; // held strobes
      logic bvalid; // write response pending
      logic [1:0] bresp; // write response code
      logic rvalid; // read data pending
      logic [1:0] rresp; // read response code
      logic [31:0] rdata; // read data
      logic [31:0] info; // registered flag word
      logic [31:0] dio; // registered direct i/o word
      logic [31:0] iin; // registered internal input word
      logic [31:0] info_prev; // flag word one cycle ago
      logic [31:0] stat; // sticky rising-flag events
      logic [31:0] mask; // interrupt enables
   } csw_state_t;

   csw_state_t state_q;
   csw_state_t state_d;
   logic [31:0] info_now; // encoded flag word

   // merge condition levels into the flag word
   csw_flag_encoder u_enc
   (
      .cond(info_cond),
      .flags(info_now)
   );

   // apply byte strobes to a register value
   function automatic logic [31:0] csw_strb(input logic [31:0] old,
      input logic [31:0] val, input logic [3:0] be);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++)
      begin
         if (be[b])
         begin
            res[b*8 +: 8] = val[b*8 +: 8];
         end
      end
      return res;
   endfunction

   // address decode to word alignment
   function automatic logic [11:0] csw_word(input logic [11:0] a);
      return {a[11:2], 2'b00};
   endfunction

   // handshake readies
   assign s_axi_awready = !state_q.aw_got && !state_q.bvalid;
   assign s_axi_wready = !state_q.w_got && !state_q.bvalid;
   assign s_axi_arready = !state_q.rvalid;
   assign s_axi_bvalid = state_q.bvalid;
   assign s_axi_bresp = state_q.bresp;
   assign s_axi_rvalid = state_q.rvalid;
   assign s_axi_rresp = state_q.rresp;
   assign s_axi_rdata = state_q.rdata;
   assign irq = |(state_q.stat & state_q.mask);

   // next-state logic
   always_comb
   begin
      logic [31:0] clr; // write-one-to-clear bits
      logic [11:0] wa; // word address of write
      clr = CSW_ZERO;
      wa = csw_word(state_q.awaddr);
      state_d = state_q;
      // sample status words every cycle
      state_d.info = info_now;
      state_d.dio = CSW_ZERO;
      state_d.dio[CSW_DIO_IN_LSB +: 8] = phys_input;
      state_d.dio[CSW_DIO_OUT_LSB +: 8] = phys_output;
      state_d.iin = CSW_ZERO;
      state_d.iin[CSW_IIN_PANEL] = panel_interface_bit;
      state_d.iin[CSW_IIN_DRV_CLR] = drive_info_clear_req;
      state_d.iin[CSW_IIN_CNT_CLR] = counter_info_clear_req;
      state_d.iin[CSW_IIN_GEN_CLR] = general_info_clear_req;
      state_d.iin[CSW_IIN_OVT_CLR] = drive_overtravel_clear_req;
      state_d.info_prev = state_q.info;
      // capture write channels independently
      if (s_axi_awvalid && s_axi_awready)
      begin
         state_d.aw_got = 1'b1;
         state_d.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         state_d.w_got = 1'b1;
         state_d.wdata = s_axi_wdata;
         state_d.wstrb = s_axi_wstrb;
      end
      // perform write once both halves are held
      if (state_q.aw_got && state_q.w_got)
      begin
         state_d.aw_got = 1'b0;
         state_d.w_got = 1'b0;
         state_d.bvalid = 1'b1;
         state_d.bresp = CSW_RESP_OKAY;
         unique case (wa)
            CSW_ADDR_IRQ_MASK:
            begin
               state_d.mask = csw_strb(state_q.mask, state_q.wdata,
                  state_q.wstrb);
            end
            CSW_ADDR_IRQ_STAT:
            begin
               clr = csw_strb(CSW_ZERO, state_q.wdata, state_q.wstrb);
            end
            CSW_ADDR_INFO, CSW_ADDR_DIO, CSW_ADDR_IIN:
            begin
               state_d.bresp = CSW_RESP_OKAY; // read-only, write ignored
            end
            default:
            begin
               state_d.bresp = CSW_RESP_SLVERR; // unmapped
            end
         endcase
      end
      // sticky events on rising flag bits; set wins over clear
      state_d.stat = (state_q.stat & ~clr) |
         (state_q.info & ~state_q.info_prev);
      // write response retires
      if (state_q.bvalid && s_axi_bready)
      begin
         state_d.bvalid = 1'b0;
      end
      // read response retires
      if (state_q.rvalid && s_axi_rready)
      begin
         state_d.rvalid = 1'b0;
      end
      // read address accepted, data next cycle
      if (s_axi_arvalid && s_axi_arready)
      begin
         state_d.rvalid = 1'b1;
         state_d.rresp = CSW_RESP_OKAY;
         unique case (csw_word(s_axi_araddr))
            CSW_ADDR_INFO: state_d.rdata = state_q.info;
            CSW_ADDR_DIO: state_d.rdata = state_q.dio;
            CSW_ADDR_IIN: state_d.rdata = state_q.iin;
            CSW_ADDR_IRQ_STAT: state_d.rdata = state_q.stat;
            CSW_ADDR_IRQ_MASK: state_d.rdata = state_q.mask;
            default:
            begin
               state_d.rdata = CSW_ZERO;
               state_d.rresp = CSW_RESP_SLVERR;
            end
         endcase
      end
   end

   // state register
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         state_q <= '0;
      end
      else
      begin
         state_q <= state_d;
      end
   end
endmodule
`default_nettype wire

// *** test/csw_host_model.sv ***
// axi4-lite host that polls the status words bank
// assumes one clock; answers are sampled at rising edges
`timescale 1ns/10ps
`default_nettype none
module csw_host_model
(
   input wire logic core_clk, // clock
   output logic [11:0] s_axi_awaddr, // write address
   output logic s_axi_awvalid, // write address valid
   input wire logic s_axi_awready, // write address ready
   output logic [31:0] s_axi_wdata, // write data
   output logic [3:0] s_axi_wstrb, // byte strobes
   output logic s_axi_wvalid, // write data valid
   input wire logic s_axi_wready, // write data ready
   input wire logic [1:0] s_axi_bresp, // write response
   input wire logic s_axi_bvalid, // response valid
   output logic s_axi_bready, // response ready
   output logic [11:0] s_axi_araddr, // read address
   output logic s_axi_arvalid, // read address valid
   input wire logic s_axi_arready, // read address ready
   input wire logic [31:0] s_axi_rdata, // read data
   input wire logic [1:0] s_axi_rresp, // read response
   input wire logic s_axi_rvalid, // read valid
   output logic s_axi_rready // read ready
);
   // bus idle from time zero
   initial
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid,
         s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
   // one read: address held until taken, rready held until the beat
   task automatic rd(input logic [11:0] a, output logic [31:0] d,
      output logic [1:0] r);
      @(posedge core_clk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'b11;
      @(posedge core_clk iff s_axi_arready) s_axi_arvalid <= 1'b0;
      @(posedge core_clk iff s_axi_rvalid) s_axi_rready <= 1'b0;
      d = s_axi_rdata;
      r = s_axi_rresp;
   endtask
   // one write: address and data offered together, each released alone
   task automatic wr(input logic [11:0] a, input logic [31:0] v,
      output logic [1:0] r);
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_wstrb <= 4'hf;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
      fork
         @(posedge core_clk iff s_axi_awready) s_axi_awvalid <= 1'b0;
         @(posedge core_clk iff s_axi_wready) s_axi_wvalid <= 1'b0;
      join
      @(posedge core_clk iff s_axi_bvalid) s_axi_bready <= 1'b0;
      r = s_axi_bresp;
   endtask
endmodule
`default_nettype wire

// *** test/csw_status_assertions.sv ***
// read data checks for the status words bank
// assumes binding to csw_status_regs; flag word lags conditions a cycle
`timescale 1ns/10ps
`default_nettype none
module csw_status_assertions
(
   input wire logic core_clk, // clock
   input wire logic rst, // async reset
   input wire logic [csw_pkg::CSW_NUM_COND-1:0] info_cond, // conditions
   input wire logic [11:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   input wire logic s_axi_arready, // read address ready
   input wire logic [31:0] s_axi_rdata, // read data
   input wire logic [1:0] s_axi_rresp, // read response
   input wire logic s_axi_rvalid // read valid
);
   import csw_pkg::*;
   localparam int POS [18] = '{0, 2, 7, 8, 9, 10, 16, 17, 18, 19, 20, 21,
      22, 26, 27, 28, 29, 31}; // flag bit of each condition
   logic [31:0] exp_d, exp_q; // expected flag word
   logic [31:0] cond_q; // flag word as the bank sampled it last edge
   logic [1:0] sel_q; // 1 flag word, 2 unmapped, 0 other
   // flag word from the live condition levels
   always_comb
   begin
      exp_d = 32'h0000_0000;
      for (int i = 0; i < CSW_NUM_COND; i++)
         exp_d[POS[i]] = info_cond[i];
   end
   // remember what the accepted read must return; the bank answers
   // with the word it registered one edge before taking the address
   always_ff @(posedge core_clk or posedge rst)
      if (rst)
         {cond_q, sel_q, exp_q} <= '0;
      else
      begin
         cond_q <= exp_d;
         if (s_axi_arvalid && s_axi_arready)
            {sel_q, exp_q} <= {((s_axi_araddr == CSW_ADDR_INFO) ? 2'd1 :
               ((s_axi_araddr == 12'h010) ? 2'd2 : 2'd0)), cond_q};
      end
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   a_info_low: assert property (s_axi_rvalid && sel_q == 2'd1 |->
      s_axi_rdata[10:0] == exp_q[10:0]) else $error("low codes wrong");
   a_info_prohib: assert property (s_axi_rvalid && sel_q == 2'd1 |->
      s_axi_rdata[19:16] == exp_q[19:16]) else $error("prohibit codes wrong");
   a_info_region: assert property (s_axi_rvalid && sel_q == 2'd1 |->
      s_axi_rdata[22:20] == exp_q[22:20]) else $error("region codes wrong");
   a_info_drive: assert property (s_axi_rvalid && sel_q == 2'd1 |->
      s_axi_rdata[27:26] == exp_q[27:26]) else $error("drive codes wrong");
   a_info_mode: assert property (s_axi_rvalid && sel_q == 2'd1 |->
      s_axi_rdata[31:28] == exp_q[31:28]) else $error("mode codes wrong");
   a_info_or_word: assert property (s_axi_rvalid && sel_q == 2'd1 |->
      s_axi_rdata == exp_q && s_axi_rresp == CSW_RESP_OKAY)
      else $error("flag word not the or of codes");
   a_read_beat: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid) else $error("read word late");
   a_unmapped_err: assert property (s_axi_rvalid && sel_q == 2'd2 |->
      s_axi_rresp == CSW_RESP_SLVERR && s_axi_rdata == CSW_ZERO)
      else $error("unmapped read not refused");
endmodule
bind csw_status_regs csw_status_assertions csw_status_assertions_inst (
   .core_clk, .rst, .info_cond, .s_axi_araddr, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid);
`default_nettype wire

// *** test/testbench.sv ***
// self-checking bench for the status words bank
// assumes csw_host_model is the only axi4-lite master
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import csw_pkg::*;
   logic core_clk = 1'b0, rst = 1'b1; // clock and reset
   logic [17:0] info_cond = '0; // condition levels
   logic [7:0] phys_input = '0, phys_output = '0; // physical i/o
   logic [4:0] iin = '0; // panel, three clears, overtravel clear
   logic [11:0] s_axi_awaddr, s_axi_araddr; // addresses
   logic [31:0] s_axi_wdata, s_axi_rdata, d; // data words
   logic [3:0] s_axi_wstrb; // strobes
   logic [1:0] s_axi_bresp, s_axi_rresp, r; // responses
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready; // aw, w
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready; // b, ar
   logic s_axi_rvalid, s_axi_rready, irq; // r channel and interrupt
   int n_fail = 0, comparisons = 0, cycles = 0, seed = 34689; // counters
   int pos [18] = '{0, 2, 7, 8, 9, 10, 16, 17, 18, 19, 20, 21, 22, 26, 27,
      28, 29, 31}; // flag bit of each condition
   csw_status_regs csw_status_regs_inst (.core_clk, .rst, .info_cond,
      .phys_input, .phys_output, .panel_interface_bit(iin[4]),
      .drive_info_clear_req(iin[3]), .counter_info_clear_req(iin[2]),
      .general_info_clear_req(iin[1]), .drive_overtravel_clear_req(iin[0]),
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .irq);
   csw_host_model host (.core_clk, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   // flag word model: or of the codes of all active conditions
   function automatic logic [31:0] info_model();
      int unsigned w = 0;
      for (int i = 0; i < 18; i++)
         if (info_cond[i] === 1'b1)
            w = w | (1 << pos[i]);
      return w;
   endfunction
   // word compare
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // flag compare on the interrupt line once it has settled
   task automatic irq_is(input logic e);
      repeat (4) @(posedge core_clk);
      comparisons++;
      if (irq !== e)
      begin
         n_fail++;
         $display("[FAIL] %0t irq %b", $time, irq);
      end
   endtask
   // verdict and end of run
   task automatic results();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial
      forever #25 core_clk = ~core_clk;
   // hang guard
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         n_fail++;
         results();
      end
   end
   initial
   begin
      repeat (12) @(posedge core_clk);
      rst <= 1'b0;
      // every condition alone, then random mixes, with the i/o words
      for (int k = 0; k < 50; k++)
      begin
         @(posedge core_clk);
         info_cond <= (k < 18) ? 18'(1 << k) : 18'($random(seed));
         {phys_input, phys_output, iin} <= 21'($random(seed));
         repeat (2) @(posedge core_clk);
         host.rd(CSW_ADDR_INFO, d, r);
         chk_word(d, info_model());
         host.rd(CSW_ADDR_DIO, d, r);
         chk_word(d, {8'h00, phys_output, 8'h00, phys_input});
         host.rd(CSW_ADDR_IIN, d, r);
         chk_word(d, {1'b0, iin[4:1], 1'b0, iin[0], 25'h000_0000});
      end
      $display("test status words done");
      // unmapped place, then a write to a read-only word
      host.rd(12'h010, d, r);
      chk_word(d, CSW_ZERO);
      chk_word(32'(r), 32'(CSW_RESP_SLVERR));
      host.wr(CSW_ADDR_INFO, 32'hffff_ffff, r);
      chk_word(32'(r), 32'(CSW_RESP_OKAY));
      host.rd(CSW_ADDR_INFO, d, r);
      chk_word(d, info_model());
      $display("test refusals done");
      // event sets status, mask gates irq, writing one clears it
      info_cond <= '0;
      host.wr(CSW_ADDR_IRQ_MASK, 32'hffff_ffff, r);
      host.wr(CSW_ADDR_IRQ_STAT, 32'hffff_ffff, r);
      irq_is(1'b0);
      info_cond <= 18'h0_0002;
      irq_is(1'b1);
      host.rd(CSW_ADDR_IRQ_STAT, d, r);
      chk_word(d, info_model());
      host.wr(CSW_ADDR_IRQ_MASK, CSW_ZERO, r);
      irq_is(1'b0);
      host.wr(CSW_ADDR_IRQ_MASK, 32'hffff_ffff, r);
      irq_is(1'b1);
      host.wr(CSW_ADDR_IRQ_STAT, 32'hffff_ffff, r);
      irq_is(1'b0);
      $display("test interrupt done");
      results();
   end
endmodule
`default_nettype wire
